/* egf_pkg.sv */
// Constants, field layout and helper functions of the GST sentence framer
//
// What this block does
// - A set command names port A or B and turns periodic output on or off.
// - A period argument gives one sentence per that many seconds.
// - Without a period argument the default output period register applies.
// - A query sends one sentence to the named port, else the arrival port.
// - $GPGST header, eight comma fields, asterisk, two checksum chars.
// - Field f1 carries UTC time hhmmss.ss of the associated fix.
// - Field f2 carries the RMS range deviation, 0000.00 to 1048.58.
// - Fields f3 and f4 are the error ellipse axis deviations in meters.
// - Field f5 is the ellipse orientation in degrees from true north.
// - Fields f6, f7, f8 carry latitude, longitude and altitude deviations.
// - Checksum is XOR of bytes between dollar and asterisk, as two hex chars.
// - UTC, RMS, latitude, longitude and altitude fields are always filled.
// - Ellipse fields f3, f4, f5 are sent empty, commas kept.
// - Deviation fields print exactly two decimals, one centimeter steps.
// - A deviation below five millimeters prints as 0000.00.
// - Range errors are taken as unbiased, so RMS equals standard deviation.
package egf_pkg;
    // Timing
    localparam int CLK_NS = 100;
    localparam int SEC_NS = 1_000_000_000;
    localparam int SEC_CYCLES = SEC_NS / CLK_NS;

    // APB register byte addresses
    localparam logic [7:0] ADDR_SET = 8'h00;
    localparam logic [7:0] ADDR_QUERY = 8'h04;
    localparam logic [7:0] ADDR_DEFPER = 8'h08;
    localparam logic [7:0] ADDR_SENT = 8'h0C;

    // Field positions inside the command words
    localparam int SET_PORT_BIT = 0;
    localparam int SET_ON_BIT = 1;
    localparam int SET_HASPER_BIT = 2;
    localparam int SET_PER_LSB = 8;
    localparam int QRY_NAMED_BIT = 0;
    localparam int QRY_PORT_BIT = 1;
    localparam int QRY_ARRIVE_BIT = 2;
    localparam logic [7:0] DEFPER_RST = 8'h01;

    // Byte positions inside the sentence
    localparam logic [5:0] IDX_F1 = 6'd7;
    localparam logic [5:0] IDX_F2 = 6'd17;
    localparam logic [5:0] IDX_F6 = 6'd28;
    localparam logic [5:0] IDX_F7 = 6'd36;
    localparam logic [5:0] IDX_F8 = 6'd44;
    localparam logic [5:0] IDX_STAR = 6'd51;
    localparam logic [5:0] IDX_CS_HI = 6'd52;
    localparam logic [5:0] IDX_CS_LO = 6'd53;
    localparam logic [5:0] IDX_CR = 6'd54;
    localparam logic [5:0] IDX_LAST = 6'd55;
    localparam logic [5:0] SD_LEN = 6'd7;
    localparam logic [5:0] UTC_LEN = 6'd9;

    // Character codes
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_HEXA = 8'h37;
    localparam logic [7:0] CH_G = 8'h47;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_T = 8'h54;

    // Deviation scaling
    localparam logic [20:0] MM_ROUND = 21'h00_0005;
    localparam logic [20:0] MM_PER_CM = 21'h00_000A;
    localparam logic [20:0] CM_MAX = 21'h0F_423F;

    typedef enum logic [0:0] {EGF_IDLE, EGF_SEND} egf_state_t;

    // Millimeters to six BCD digits of centimeters, rounded and saturated
    function automatic logic [23:0] mm_to_bcd(input logic [19:0] mm);
        logic [20:0] cm;
        logic [23:0] r;
        r = '0;
        cm = ({1'b0, mm} + MM_ROUND) / MM_PER_CM;
        if (cm > CM_MAX) begin
            cm = CM_MAX;
        end
        for (int i = 0; i < 6; i++) begin
            r[i*4 +: 4] = 4'(cm % MM_PER_CM);
            cm = cm / MM_PER_CM;
        end
        return r;
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n < 4'hA) ? (CH_ZERO + {4'h0, n}) : (CH_HEXA + {4'h0, n});
    endfunction
endpackage

/* egf_tick.sv */
// One-second tick generator for the periodic sentence timers
`timescale 1ns/1ps
module egf_tick #(
    parameter int CYC = egf_pkg::SEC_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Tick
    output logic o_tick
);
    import egf_pkg::*;

    logic [23:0] cnt_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 24'h00_0000;
            o_tick <= 1'b0;
        end else if (cnt_q == 24'(CYC - 1)) begin
            cnt_q <= 24'h00_0000;
            o_tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 24'h00_0001;
            o_tick <= 1'b0;
        end
    end
endmodule

/* egf_buf2.sv */
// Two-entry skid buffer between the sentence builder and the serial ports
`timescale 1ns/1ps
module egf_buf2 #(
    parameter int W = 9
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Filling side
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    // Draining side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    logic [W-1:0] spare_q;
    logic spare_v_q;
    logic push;
    logic pop;

    // Ready is a flop: the spare slot catches the word in flight on a stall
    assign o_ready = !spare_v_q;
    assign push = i_valid && !spare_v_q;
    assign pop = o_valid && i_ready;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_valid <= 1'b0;
            o_data <= '0;
            spare_q <= '0;
            spare_v_q <= 1'b0;
        end else if (!o_valid || pop) begin
            if (spare_v_q) begin
                o_data <= spare_q;
                o_valid <= 1'b1;
                spare_v_q <= 1'b0;
            end else begin
                o_data <= i_data;
                o_valid <= push;
            end
        end else if (push) begin
            spare_q <= i_data;
            spare_v_q <= 1'b1;
        end
    end
endmodule

/* egf_framer.sv */
// GST error statistics sentence framer with APB control registers
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module egf_framer #(
    parameter int TICK_CYCLES = egf_pkg::SEC_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Navigation solution
    input wire logic [31:0] i_utc_bcd,
    input wire logic [19:0] i_rms_mm,
    input wire logic [19:0] i_lat_mm,
    input wire logic [19:0] i_lon_mm,
    input wire logic [19:0] i_alt_mm,
    // Sentence byte stream
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_port,
    input wire logic i_tx_ready
);
    import egf_pkg::*;

    egf_state_t state_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    logic hit;
    logic wr_en;
    logic set_wr;
    logic qry_wr;
    logic set_port;
    logic qry_port;
    logic [1:0] en_q;
    logic [7:0] per_q [2];
    logic [7:0] cnt_q [2];
    logic [7:0] defper_q;
    logic [1:0] per_hit;
    logic [1:0] per_pend_q;
    logic [1:0] qry_pend_q;
    logic [1:0] any_pend;
    logic [15:0] sent_q;
    logic tick;
    logic start;
    logic port_sel;
    logic port_q;
    logic push;
    logic buf_ready;
    logic [5:0] idx_q;
    logic [7:0] csum_q;
    logic [7:0] byte_d;
    logic [31:0] utc_q;
    logic [23:0] sd_q [4];

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state so that every answer comes from a flop

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign hit = (i_paddr == ADDR_SET) || (i_paddr == ADDR_QUERY) ||
                 (i_paddr == ADDR_DEFPER) || (i_paddr == ADDR_SENT);
    assign wr_en = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
    assign set_wr = wr_en && (i_paddr == ADDR_SET);
    assign qry_wr = wr_en && (i_paddr == ADDR_QUERY);
    assign set_port = i_pwdata[SET_PORT_BIT];
    assign qry_port = i_pwdata[QRY_NAMED_BIT] ? i_pwdata[QRY_PORT_BIT] :
                      i_pwdata[QRY_ARRIVE_BIT];

    always_comb begin
        rd_d = 32'h0000_0000;
        case (i_paddr)
            ADDR_SET: rd_d = {per_q[1], per_q[0], 14'h0000, en_q};
            ADDR_QUERY: rd_d = {26'h000_0000, qry_pend_q, per_pend_q,
                                port_q, state_q == EGF_SEND};
            ADDR_DEFPER: rd_d = {24'h00_0000, defper_q};
            ADDR_SENT: rd_d = {16'h0000, sent_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= i_psel && i_penable && !pready_q;
            if (i_psel && i_penable && !pready_q) begin
                pslverr_q <= !hit;
                prdata_q <= (!i_pwrite && hit) ? rd_d : 32'h0000_0000;
            end else begin
                pslverr_q <= 1'b0;
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            defper_q <= DEFPER_RST;
        end else if (wr_en && (i_paddr == ADDR_DEFPER)) begin
            defper_q <= i_pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-port enable and period timers

    egf_tick #(.CYC(TICK_CYCLES)) u_tick (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .o_tick(tick)
    );

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            en_q <= 2'b00;
            per_q[0] <= 8'h00;
            per_q[1] <= 8'h00;
        end else if (set_wr) begin
            en_q[set_port] <= i_pwdata[SET_ON_BIT];
            if (i_pwdata[SET_ON_BIT]) begin
                // Zero period stands for the default register
                per_q[set_port] <= i_pwdata[SET_HASPER_BIT] ?
                    i_pwdata[SET_PER_LSB +: 8] : 8'h00;
            end
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_port
        logic [7:0] eff;
        assign eff = (per_q[p] == 8'h00) ? defper_q : per_q[p];
        assign per_hit[p] = tick && en_q[p] &&
                            ({1'b0, cnt_q[p]} + 9'h001 >= {1'b0, eff});

        always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                cnt_q[p] <= 8'h00;
            end else if (set_wr && (set_port == p)) begin
                cnt_q[p] <= 8'h00;
            end else if (per_hit[p]) begin
                cnt_q[p] <= 8'h00;
            end else if (tick && en_q[p]) begin
                cnt_q[p] <= cnt_q[p] + 8'h01;
            end
        end

        // A new request in the cycle a sentence starts is kept
        always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                per_pend_q[p] <= 1'b0;
                qry_pend_q[p] <= 1'b0;
            end else begin
                per_pend_q[p] <= per_hit[p] ||
                    (per_pend_q[p] && !(start && port_sel == p));
                qry_pend_q[p] <= (qry_wr && qry_port == p) ||
                    (qry_pend_q[p] && !(start && port_sel == p));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sentence sequencer; port A is served first when both wait

    assign any_pend = per_pend_q | qry_pend_q;
    assign start = (state_q == EGF_IDLE) && (any_pend != 2'b00);
    assign port_sel = !any_pend[0];
    assign push = (state_q == EGF_SEND) && buf_ready;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= EGF_IDLE;
            idx_q <= 6'd0;
            port_q <= 1'b0;
            sent_q <= 16'h0000;
        end else begin
            case (state_q)
                EGF_IDLE: begin
                    if (start) begin
                        state_q <= EGF_SEND;
                        idx_q <= 6'd0;
                        port_q <= port_sel;
                    end
                end
                EGF_SEND: begin
                    if (push) begin
                        idx_q <= idx_q + 6'd1;
                        if (idx_q == IDX_LAST) begin
                            state_q <= EGF_IDLE;
                            sent_q <= sent_q + 16'h0001;
                        end
                    end
                end
                default: state_q <= EGF_IDLE;
            endcase
        end
    end

    // Statistics are frozen at the start so a sentence is self-consistent
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            utc_q <= 32'h0000_0000;
            for (int i = 0; i < 4; i++) begin
                sd_q[i] <= 24'h00_0000;
            end
        end else if (start) begin
            utc_q <= i_utc_bcd;
            sd_q[0] <= mm_to_bcd(i_rms_mm);
            sd_q[1] <= mm_to_bcd(i_lat_mm);
            sd_q[2] <= mm_to_bcd(i_lon_mm);
            sd_q[3] <= mm_to_bcd(i_alt_mm);
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            csum_q <= 8'h00;
        end else if (start) begin
            csum_q <= 8'h00;
        end else if (push && idx_q != 6'd0 && idx_q < IDX_STAR) begin
            csum_q <= csum_q ^ byte_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Character at the current position

    function automatic logic [7:0] sd_char(input logic [23:0] v,
                                           input logic [5:0] o);
        int k;
        k = (o < 6'd4) ? int'(o) : int'(o) - 1;
        if (o == 6'd4) begin
            return CH_DOT;
        end
        return CH_ZERO | {4'h0, 4'(v >> (20 - 4 * k))};
    endfunction

    always_comb begin
        int k;
        logic [5:0] o;
        k = 0;
        o = idx_q - IDX_F1;
        byte_d = CH_COMMA;
        if (idx_q == 6'd0) begin
            byte_d = CH_DOLLAR;
        end else if (idx_q < 6'd6) begin
            case (idx_q)
                6'd1: byte_d = CH_G;
                6'd2: byte_d = CH_P;
                6'd3: byte_d = CH_G;
                6'd4: byte_d = CH_S;
                default: byte_d = CH_T;
            endcase
        end else if (idx_q >= IDX_F1 && idx_q < IDX_F1 + UTC_LEN) begin
            k = (o < 6'd6) ? int'(o) : int'(o) - 1;
            byte_d = (o == 6'd6) ? CH_DOT :
                CH_ZERO | {4'h0, 4'(utc_q >> (28 - 4 * k))};
        end else if (idx_q >= IDX_F2 && idx_q < IDX_F2 + SD_LEN) begin
            byte_d = sd_char(sd_q[0], idx_q - IDX_F2);
        end else if (idx_q >= IDX_F6 && idx_q < IDX_F6 + SD_LEN) begin
            byte_d = sd_char(sd_q[1], idx_q - IDX_F6);
        end else if (idx_q >= IDX_F7 && idx_q < IDX_F7 + SD_LEN) begin
            byte_d = sd_char(sd_q[2], idx_q - IDX_F7);
        end else if (idx_q >= IDX_F8 && idx_q < IDX_F8 + SD_LEN) begin
            byte_d = sd_char(sd_q[3], idx_q - IDX_F8);
        end else if (idx_q == IDX_STAR) begin
            byte_d = CH_STAR;
        end else if (idx_q == IDX_CS_HI) begin
            byte_d = hex_char(csum_q[7:4]);
        end else if (idx_q == IDX_CS_LO) begin
            byte_d = hex_char(csum_q[3:0]);
        end else if (idx_q == IDX_CR) begin
            byte_d = CH_CR;
        end else if (idx_q == IDX_LAST) begin
            byte_d = CH_LF;
        end
        // Remaining positions are separators; f3 to f5 stay empty
    end

    egf_buf2 #(.W(9)) u_buf (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_valid(state_q == EGF_SEND),
        .i_data({port_q, byte_d}),
        .o_ready(buf_ready),
        .o_valid(o_tx_valid),
        .o_data({o_tx_port, o_tx_data}),
        .i_ready(i_tx_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    a_set_enable: assert property (
        set_wr |=> en_q[$past(set_port)] == $past(i_pwdata[SET_ON_BIT]))
        else $error("set command did not update the port enable");
    a_period_fire: assert property (
        tick && en_q[0] && per_q[0] != 8'h00 && cnt_q[0] == per_q[0] - 8'h01
        |=> per_pend_q[0])
        else $error("explicit period did not raise a sentence request");
    a_query_pend: assert property (
        qry_wr |=> qry_pend_q[$past(qry_port)] || state_q == EGF_SEND)
        else $error("query did not raise a request on its port");
    a_header_start: assert property (
        push && idx_q == 6'd0 |-> byte_d == CH_DOLLAR ##1 idx_q == 6'd1)
        else $error("sentence does not open with the dollar sign");
    a_utc_point: assert property (
        push && idx_q == IDX_F1 + 6'd6 |-> byte_d == CH_DOT)
        else $error("time field decimal point misplaced");
    a_two_decimals: assert property (
        push && (idx_q == IDX_F2 + 6'd4 || idx_q == IDX_F8 + 6'd4)
        |-> byte_d == CH_DOT)
        else $error("deviation field lacks two decimals");
    a_empty_fields: assert property (
        push && idx_q > IDX_F2 + 6'd6 && idx_q < IDX_F6 |-> byte_d == CH_COMMA)
        else $error("ellipse fields are not empty");
    a_small_zero: assert property (
        start && i_rms_mm < 20'h0_0005 |=> sd_q[0] == 24'h00_0000)
        else $error("deviation below five millimeters not zero");
    a_csum_high: assert property (
        push && idx_q == IDX_CS_HI |->
        (byte_d >= CH_ZERO && byte_d <= 8'h39) ||
        (byte_d >= 8'h41 && byte_d <= 8'h46))
        else $error("checksum character wrong");
    a_line_end: assert property (
        push && idx_q == IDX_CR |-> byte_d == CH_CR
        ##[1:8] (push && idx_q == IDX_LAST && byte_d == CH_LF))
        else $error("sentence does not end with CR LF");

    c_port_b: cover property (start && port_sel);
    c_query: cover property (qry_wr ##[1:20] start);
    c_stall: cover property (o_tx_valid && !i_tx_ready && !buf_ready);
endmodule

/* egf_sink.sv */
// Serial port receiver model that collects the sentence byte stream
`timescale 1ns/1ps
module egf_sink (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Byte stream
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    input wire logic i_port,
    output logic o_ready,
    // Control
    input wire logic i_stall
);
    logic [8:0] got[$];
    logic [1:0] ph_q;
    // A slow port takes one byte in four, so the skid buffer fills up
    assign o_ready = !i_stall || ph_q == 2'h3;
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
            if (i_valid && o_ready) begin
                got.push_back({i_port, i_data});
            end
        end
    end
endmodule

/* egf_framer_bench.sv */
// Self-checking testbench of the GST sentence framer
`timescale 1ns/1ps
module egf_framer_bench;
    import egf_pkg::*;
    typedef struct {
        logic [31:0] utc;
        logic [19:0] rms, lat, lon, alt;
        logic port, stall;
    } egf_row_t;
    logic clk, nrst, psel, pen, pwr, pready, perr, tv, tp, tr, stall, e;
    logic [7:0] paddr, td;
    logic [31:0] pwd, prd, utc, r;
    logic [19:0] rms, lat, lon, alt;
    int n_fail, n_tests, cyc, nsent, k;
    egf_row_t rows[4] = '{
        '{32'h2206_3200, 20'h0_5712, 20'h0_4254, 20'h0_23A0, 20'h0_5A28,
            1'h0, 1'h0},
        '{32'h0000_0000, 20'h0_0004, 20'h0_0005, 20'h0_000E, 20'h0_000F,
            1'h1, 1'h1},
        '{32'h2359_5995, 20'hF_FFFF, 20'h1_869A, 20'h1_869F, 20'h0_0000,
            1'h0, 1'h1},
        '{32'h1234_5678, 20'h0_0063, 20'h0_0C35, 20'h0_0001, 20'h0_270F,
            1'h1, 1'h0}};
    egf_row_t x;

    egf_framer #(.TICK_CYCLES(50)) egf_framer_i (.i_clk(clk), .i_nrst(nrst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready), .o_pslverr(perr),
        .i_utc_bcd(utc), .i_rms_mm(rms), .i_lat_mm(lat), .i_lon_mm(lon),
        .i_alt_mm(alt), .o_tx_valid(tv), .o_tx_data(td), .o_tx_port(tp),
        .i_tx_ready(tr));
    egf_sink egf_sink_i (.i_clk(clk), .i_nrst(nrst), .i_valid(tv),
        .i_data(td), .i_port(tp), .o_ready(tr), .i_stall(stall));

    ////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Entered just after a rising edge; ready is sampled at rising edges
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        r = prd;
        e = perr;
    endtask

    task idle;
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask

    function automatic string sd(input logic [19:0] mm);
        int c;
        c = (int'(mm) + 5) / 10;
        if (c > 999999) begin
            c = 999999;
        end
        return $sformatf("%04d.%02d", c / 100, c % 100);
    endfunction

    function automatic byte hx(input logic [3:0] v);
        return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
    endfunction

    task expect_snt(input egf_row_t s);
        string b, m;
        byte cs;
        int n;
        b = {"GPGST,", $sformatf("%06h.%02h", s.utc[31:8], s.utc[7:0]), ",",
            sd(s.rms), ",,,,", sd(s.lat), ",", sd(s.lon), ",", sd(s.alt)};
        cs = 8'h00;
        foreach (b[i]) cs ^= b[i];
        m = $sformatf("$%s*%c%c%c%c", b, hx(cs[7:4]), hx(cs[3:0]),
            8'h0D, 8'h0A);
        n = 0;
        while (egf_sink_i.got.size() < 56 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        for (int i = 0; i < 56; i++) begin
            check("sentence byte", {s.port, m[i]}, egf_sink_i.got.pop_front());
        end
        nsent++;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        {nrst, psel, pen, pwr, stall} = 5'h00;
        paddr = 8'h00;
        pwd = 32'h0000_0000;
        {utc, rms, lat, lon, alt} = '0;
        repeat (4) @(posedge clk);
        check("tx valid in reset", 32'h0, tv);
        nrst <= 1'h1;
        @(posedge clk);
        apb(1'h0, ADDR_DEFPER, 32'h0);
        check("default period", 32'h1, r);
        apb(1'h1, ADDR_SENT, 32'h0000_0005);
        apb(1'h0, ADDR_SENT, 32'h0);
        check("sent count", 32'h0, r);
        apb(1'h0, 8'h10, 32'h0);
        check("slave error", 32'h1, e);
        idle();
        foreach (rows[i]) begin
            stall <= rows[i].stall;
            {utc, rms, lat, lon, alt} <= {rows[i].utc, rows[i].rms,
                rows[i].lat, rows[i].lon, rows[i].alt};
            apb(1'h1, ADDR_QUERY, {29'h0, 1'h0, rows[i].port, 1'h1});
            idle();
            expect_snt(rows[i]);
        end
        // Unnamed query goes back to the port it came from
        apb(1'h1, ADDR_QUERY, 32'h0000_0004);
        idle();
        expect_snt(rows[3]);
        x = rows[3];
        x.port = 1'h0;
        apb(1'h1, ADDR_QUERY, 32'h0000_0001);
        apb(1'h1, ADDR_QUERY, 32'h0000_0003);
        idle();
        expect_snt(x);
        expect_snt(rows[3]);
        apb(1'h1, ADDR_DEFPER, 32'h0000_0003);
        apb(1'h1, ADDR_SET, 32'h0000_0206);
        apb(1'h1, ADDR_SET, 32'h0000_0003);
        idle();
        repeat (500) @(posedge clk);
        apb(1'h1, ADDR_SET, 32'h0000_0000);
        apb(1'h1, ADDR_SET, 32'h0000_0001);
        apb(1'h0, ADDR_SET, 32'h0);
        idle();
        check("set readback", 32'h0002_0000, r);
        repeat (200) @(posedge clk);
        k = 0;
        foreach (egf_sink_i.got[i]) k += egf_sink_i.got[i][8];
        check("port B bytes", 32'd168, k);
        check("port A bytes", 32'd280, egf_sink_i.got.size() - k);
        nsent += 8;
        egf_sink_i.got.delete();
        apb(1'h0, ADDR_SENT, 32'h0);
        idle();
        check("sent count", nsent, r);
        // Reset in mid-sentence must silence the stream and clear enables
        apb(1'h1, ADDR_SET, 32'h0000_0002);
        apb(1'h1, ADDR_QUERY, 32'h0000_0001);
        idle();
        repeat (20) @(posedge clk);
        nrst <= 1'h0;
        @(negedge clk);
        check("tx valid in reset", 32'h0, tv);
        @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        apb(1'h0, ADDR_SET, 32'h0);
        idle();
        check("set after reset", 32'h0, r);
        give_verdict();
    end
endmodule
